// ### design/serial_eeprom_bus_slave.sv
// two-wire eeprom target: protocol engine and write staging fifo
//
// Overview of operation
// - Accept address word only if top four bits are the 1010 type pattern.
// - Next three bits must equal the three chip select pins.
// - Unconnected chip select pins count as low.
// - Module variant compares the three select bits against zero instead.
// - Address word bit 0 high starts a read, low a write.
// - Match is acknowledged with zero; mismatch goes to standby until start.
// - Write-protect high keeps the whole array from being modified.
// - Write: two address bytes then data byte, each acknowledged; stop ends.
// - Stop after an unprotected data byte starts timed programming; bus ignored meanwhile.
// - Page write accepts up to 64 data bytes, each acknowledged.
// - Only low six address bits increment during writes; page wraps.
// - Beyond 64 bytes the page address wraps and overwrites earlier bytes.
// - Address words during programming get no ack until it has finished.
// - Address counter holds last address plus one between operations.
// - Read address wraps from last array byte to first.
// - Current read shifts out the byte at the counter address.
// - Controller ack after read byte: increment and send the next byte.
// - Bytes go msb first; receiver drives zero on the ninth clock.
// - Programming lasts at most 5 ms from the stop.
// - Start and stop are seen at any time except during programming; stop returns to standby unless it starts programming.
`timescale 1ns/1ns
`default_nettype none

module write_fifo #(
   parameter int WIDTH = 23,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             en,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = DEPTH[AW:0];

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = (cnt_q != FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_q <= '{default: '0};
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (en) begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : write_fifo

module serial_eeprom_bus_slave #(
   parameter int PROG_CYCLES_P = eeprom_pkg::PROG_CYCLES
) (
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic                  clk_en,
   input  wire logic                  scl_in,
   output logic                       scl_out,
   output logic                       scl_oe,
   input  wire logic                  sda_in,
   output logic                       sda_out,
   output logic                       sda_oe,
   input  wire logic                  chip_select_pin_high,
   input  wire logic                  chip_select_pin_mid,
   input  wire logic                  chip_select_pin_low,
   input  wire logic                  write_protect,
   input  wire logic                  module_variant,
   output logic [14:0]                mem_rd_addr,
   input  wire logic [7:0]            mem_rd_data,
   output logic                       mem_wr_valid,
   input  wire logic                  mem_wr_ready,
   output var eeprom_pkg::wr_entry_t  mem_wr_entry,
   output logic                       prog_start,
   output logic                       prog_busy
);
   import eeprom_pkg::*;

   pin_sample_t pins, s1_q, s2_q;
   logic        scl_p_q, sda_p_q;
   logic        scl_rise, scl_fall, start_c, stop_c, dev_ok;
   logic [2:0]  cs_exp;

   bus_state_t  st_q, st_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [7:0]  sh_q, sh_d, tx_q, tx_d;
   logic [14:0] addr_q, addr_d;
   logic        ack_q, ack_d, rd_q, rd_d, load_q, load_d;
   logic        mack_q, mack_d, wrote_q, wrote_d;
   logic        push_q, push_d, drv_q, drv_d, pst_q, pst_d;
   wr_entry_t   ent_q, ent_d;
   logic [16:0] prog_q, prog_d;
   logic        fifo_ready;

   // pins float low inside the pad; here they arrive already resolved
   assign pins = '{scl: scl_in, sda: sda_in,
                   cs: {chip_select_pin_high, chip_select_pin_mid,
                        chip_select_pin_low},
                   wp: write_protect, modv: module_variant};

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s1_q    <= '{scl: 1'b1, sda: 1'b1, default: '0};
         s2_q    <= '{scl: 1'b1, sda: 1'b1, default: '0};
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else if (clk_en) begin
         s1_q    <= pins;
         s2_q    <= s1_q;
         scl_p_q <= s2_q.scl;
         sda_p_q <= s2_q.sda;
      end
   end

   assign scl_rise = s2_q.scl & ~scl_p_q;
   assign scl_fall = ~s2_q.scl & scl_p_q;
   assign start_c  = s2_q.scl & scl_p_q & sda_p_q & ~s2_q.sda;
   assign stop_c   = s2_q.scl & scl_p_q & ~sda_p_q & s2_q.sda;
   assign cs_exp   = s2_q.modv ? MODULE_CS : s2_q.cs;
   assign dev_ok   = (sh_q[7:4] == DEV_TYPE) && (sh_q[3:1] == cs_exp);

   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      tx_d    = tx_q;
      addr_d  = addr_q;
      ack_d   = ack_q;
      rd_d    = rd_q;
      load_d  = 1'b0;
      mack_d  = mack_q;
      wrote_d = wrote_q;
      push_d  = push_q & ~fifo_ready;
      ent_d   = ent_q;
      prog_d  = prog_q;
      pst_d   = 1'b0;
      if (st_q == ST_BUSY) begin
         // inputs ignored entirely, so polling words see no ack
         prog_d = prog_q - 1'b1;
         if (prog_q <= 17'd1) begin
            st_d = ST_IDLE;
         end
      end else if (stop_c) begin
         st_d    = ST_IDLE;
         ack_d   = 1'b0;
         rd_d    = 1'b0;
         wrote_d = 1'b0;
         if (wrote_q) begin
            st_d   = ST_BUSY;
            prog_d = PROG_CYCLES_P[16:0];
            pst_d  = 1'b1;
         end
      end else if (start_c) begin
         // a repeated start skips the programming cycle of an unfinished write; bytes already staged still drain
         st_d    = ST_DEV;
         cnt_d   = 4'h0;
         ack_d   = 1'b0;
         rd_d    = 1'b0;
         wrote_d = 1'b0;
      end else if (load_q) begin
         tx_d = mem_rd_data;
         rd_d = 1'b1;
      end else if (scl_rise && st_q != ST_IDLE) begin
         if (cnt_q < CNT_BYTE) begin
            sh_d = {sh_q[6:0], s2_q.sda};
         end else if (cnt_q == CNT_BYTE) begin
            mack_d = ~s2_q.sda;
         end
         cnt_d = cnt_q + 4'h1;
      end else if (scl_fall && st_q != ST_IDLE) begin
         if (cnt_q < CNT_BYTE) begin
            if (st_q == ST_RDAT) begin
               tx_d = {tx_q[6:0], 1'b0};
            end
         end else if (cnt_q == CNT_BYTE) begin
            case (st_q)
               ST_DEV: begin
                  if (dev_ok) begin
                     ack_d = 1'b1;
                  end else begin
                     st_d = ST_IDLE;
                  end
               end
               ST_AHI: begin
                  ack_d = 1'b1;
                  addr_d[14:8] = sh_q[6:0];
               end
               ST_ALO: begin
                  ack_d = 1'b1;
                  addr_d[7:0] = sh_q;
               end
               ST_WDAT: begin
                  ack_d = 1'b1;
                  ent_d = '{addr: addr_q, data: sh_q};
                  push_d = ~s2_q.wp;
                  wrote_d = wrote_q | ~s2_q.wp;
                  addr_d[PAGE_BITS-1:0] = addr_q[PAGE_BITS-1:0] + 6'h01;
               end
               ST_RDAT: rd_d = 1'b0; // release for the controller ack
               default: st_d = ST_IDLE;
            endcase
         end else begin
            ack_d = 1'b0;
            cnt_d = 4'h0;
            case (st_q)
               ST_DEV: begin
                  if (sh_q[0]) begin
                     st_d   = ST_RDAT;
                     load_d = 1'b1;
                  end else begin
                     st_d = ST_AHI;
                  end
               end
               ST_AHI: st_d = ST_ALO;
               ST_ALO: st_d = ST_WDAT;
               ST_RDAT: begin
                  addr_d = addr_q + 15'h0001;
                  if (mack_q) begin
                     load_d = 1'b1;
                  end else begin
                     st_d = ST_IDLE;
                  end
               end
               default: st_d = st_q;
            endcase
         end
      end
      drv_d = ack_d | (rd_d & ~tx_d[7]);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_q    <= ST_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         tx_q    <= 8'h00;
         addr_q  <= ADDR_RESET;
         ack_q   <= 1'b0;
         rd_q    <= 1'b0;
         load_q  <= 1'b0;
         mack_q  <= 1'b0;
         wrote_q <= 1'b0;
         push_q  <= 1'b0;
         ent_q   <= '0;
         prog_q  <= 17'h00000;
         drv_q   <= 1'b0;
         pst_q   <= 1'b0;
      end else if (clk_en) begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         tx_q    <= tx_d;
         addr_q  <= addr_d;
         ack_q   <= ack_d;
         rd_q    <= rd_d;
         load_q  <= load_d;
         mack_q  <= mack_d;
         wrote_q <= wrote_d;
         push_q  <= push_d;
         ent_q   <= ent_d;
         prog_q  <= prog_d;
         drv_q   <= drv_d;
         pst_q   <= pst_d;
      end
   end

   // staged page bytes drain to the array; a full fifo stretches scl low
   // rather than dropping a byte, which costs bus time on slow arrays
   write_fifo #(
      .WIDTH ($bits(wr_entry_t)),
      .DEPTH (FIFO_WORDS)
   ) u_fifo (
      .clk       (sys_clk),
      .rst       (reset),
      .en        (clk_en),
      .in_valid  (push_q),
      .in_ready  (fifo_ready),
      .in_data   (ent_q),
      .out_valid (mem_wr_valid),
      .out_ready (mem_wr_ready),
      .out_data  (mem_wr_entry)
   );

   assign scl_out     = 1'b0;
   assign scl_oe      = push_q & ~fifo_ready;
   assign sda_out     = 1'b0;
   assign sda_oe      = drv_q;
   assign mem_rd_addr = addr_q;
   assign prog_start  = pst_q;
   assign prog_busy   = (st_q == ST_BUSY);
endmodule : serial_eeprom_bus_slave

`default_nettype wire

// ### include/eeprom_pkg.sv
// shared constants and types of the two-wire eeprom target
package eeprom_pkg;
   localparam int          ADDR_W       = 15;
   localparam int          PAGE_BITS    = 6;
   localparam logic [3:0]  DEV_TYPE     = 4'ha;
   localparam logic [2:0]  MODULE_CS    = 3'h0;
   localparam logic [3:0]  CNT_BYTE     = 4'h8;
   localparam logic [3:0]  CNT_ACK      = 4'h9;
   localparam logic [14:0] ADDR_RESET   = 15'h0000;
   localparam int          FIFO_WORDS   = 4;
   localparam int          PROG_TIME_MS = 5;
   localparam int          SYS_CLK_HZ   = 20000000;
   // longest time: rounds down
   localparam int          PROG_CYCLES  = PROG_TIME_MS * (SYS_CLK_HZ / 1000);

   typedef enum logic [2:0] {
      ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDAT, ST_RDAT, ST_BUSY
   } bus_state_t;

   typedef struct packed {
      logic [14:0] addr;
      logic [7:0]  data;
   } wr_entry_t;

   typedef struct packed {
      logic       scl;
      logic       sda;
      logic [2:0] cs;
      logic       wp;
      logic       modv;
   } pin_sample_t;
endpackage : eeprom_pkg

// ### test/host.sv
// open-drain two-wire bus controller model
`timescale 1ns/1ns
`default_nettype none

module host (
   input  wire logic clk,
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_low = 1'b0,
   output logic      sda_low = 1'b0
);
   // release scl and wait out stretching by the target for up to 5000 cycles
   task automatic scl_hi();
      int i;
      scl_low <= 1'b0;
      for (i = 0; i < 5000 && scl !== 1'b1; i++) @(posedge clk);
      // four high cycles plus four low ones give a 400 ns bit time
      repeat (3) @(posedge clk);
   endtask : scl_hi

   task automatic start();
      sda_low <= 1'b0;
      repeat (2) @(posedge clk);
      scl_hi();
      sda_low <= 1'b1;
      repeat (4) @(posedge clk);
      scl_low <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : start

   task automatic stop();
      sda_low <= 1'b1;
      repeat (2) @(posedge clk);
      scl_hi();
      sda_low <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : stop

   task automatic xbit(input logic b, output logic r);
      sda_low <= !b;
      repeat (2) @(posedge clk);
      scl_hi();
      r = sda;
      scl_low <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : xbit

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(b[i], r);
      xbit(1'b1, r);
      ack = !r;
   endtask : wbyte

   // a cleared ack_in leaves the ninth bit released, which ends a read
   task automatic rbyte(input logic ack_in, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) xbit(1'b1, b[i]);
      xbit(!ack_in, r);
   endtask : rbyte
endmodule : host

`default_nettype wire

// ### test/eeprom_checker.sv
// concurrent checks on the eeprom target ports
`timescale 1ns/1ns
`default_nettype none

module eeprom_checker import eeprom_pkg::*; #(
   parameter int PROG_CYCLES_P = 200
) (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        scl_in,
   input wire logic        scl_oe,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        write_protect,
   input wire logic [14:0] mem_rd_addr,
   input wire logic        mem_wr_valid,
   input wire logic        mem_wr_ready,
   input wire wr_entry_t   mem_wr_entry,
   input wire logic        prog_start,
   input wire logic        prog_busy
);
   int cnt_q;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 0;
      end else begin
         cnt_q <= prog_busy ? cnt_q + 1 : 0;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   chk_sda_open: assert property (sda_out == 1'b0) else $error("sda driven high");
   // data and ack may only move at an edge where scl was still sampled low
   chk_sda_settle: assert property ($changed(sda_oe) |-> !$past(scl_in))
      else $error("sda drive moved while scl high");
   chk_prog_pulse: assert property (prog_start |=> !prog_start) else $error("long pulse");
   chk_busy_follows: assert property (prog_start |-> ##[0:1] prog_busy)
      else $error("no busy after start");
   chk_busy_silent: assert property (prog_busy |-> !sda_oe && !scl_oe)
      else $error("bus driven while busy");
   chk_busy_bound: assert property (cnt_q <= PROG_CYCLES_P)
      else $error("busy too long");
   chk_fifo_hold: assert property (mem_wr_valid && !mem_wr_ready |=>
      mem_wr_valid && $stable(mem_wr_entry)) else $error("entry dropped");
   chk_wp_block: assert property (write_protect [*8] |-> !prog_start)
      else $error("program under protect");
   chk_addr_frozen: assert property (prog_busy && $past(prog_busy) |->
      $stable(mem_rd_addr)) else $error("address moved while busy");
endmodule : eeprom_checker

bind serial_eeprom_bus_slave eeprom_checker #(.PROG_CYCLES_P(PROG_CYCLES_P)) i_eeprom_checker (
   .sys_clk, .reset, .scl_in, .scl_oe, .sda_out, .sda_oe, .write_protect, .mem_rd_addr,
   .mem_wr_valid, .mem_wr_ready, .mem_wr_entry, .prog_start, .prog_busy);

`default_nettype wire

// ### test/serial_eeprom_bus_slave_bench.sv
// self-checking bench of the two-wire eeprom target
`timescale 1ns/1ns
`default_nettype none

module serial_eeprom_bus_slave_bench;
   import eeprom_pkg::*;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  cs = 3'h0;
   logic        wp = 1'b0;
   logic        modv = 1'b0;
   logic        stall = 1'b0;
   logic        ack;
   logic [7:0]  rd;
   logic [7:0]  mem [32768];
   logic [14:0] rd_addr;
   wr_entry_t   entry;
   logic        scl_oe, sda_oe, m_scl, m_sda, wr_valid, busy;
   int          mismatches = 0;
   int          total_checks = 0;
   int          pushes = 0;
   wire logic   scl = !(m_scl || scl_oe);
   wire logic   sda = !(m_sda || sda_oe);

   always #25 sys_clk = !sys_clk;

   serial_eeprom_bus_slave #(.PROG_CYCLES_P(200)) i_serial_eeprom_bus_slave (
      .sys_clk, .reset, .clk_en(1'b1), .scl_in(scl), .scl_out(), .scl_oe,
      .sda_in(sda), .sda_out(), .sda_oe, .chip_select_pin_high(cs[2]),
      .chip_select_pin_mid(cs[1]), .chip_select_pin_low(cs[0]), .write_protect(wp),
      .module_variant(modv), .mem_rd_addr(rd_addr), .mem_rd_data(mem[rd_addr]),
      .mem_wr_valid(wr_valid), .mem_wr_ready(!stall), .mem_wr_entry(entry),
      .prog_start(), .prog_busy(busy));
   host i_host (.clk(sys_clk), .scl, .sda, .scl_low(m_scl), .sda_low(m_sda));

   // array stand-in: takes each fifo entry at once unless stalled
   always @(posedge sys_clk) begin
      if (wr_valid && !stall) begin
         mem[entry.addr] <= entry.data;
         pushes <= pushes + 1;
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      if (mismatches == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   task automatic dev(input logic [7:0] w);
      i_host.start();
      i_host.wbyte(w, ack);
   endtask : dev

   task automatic wr(input logic [7:0] b);
      i_host.wbyte(b, ack);
   endtask : wr

   task automatic t_select();
      dev(8'hb0);
      check(ack, 1'b0);
      cs <= 3'h5;
      dev(8'ha0);
      check(ack, 1'b0);
      dev(8'haa);
      check(ack, 1'b1);
      modv <= 1'b1;
      dev(8'haa);
      check(ack, 1'b0);
      dev(8'ha0);
      check(ack, 1'b1);
      i_host.stop();
      modv <= 1'b0;
      cs <= 3'h0;
   endtask : t_select

   // 66 bytes from offset 5: the last two wrap onto the first two
   task automatic t_page();
      int base;
      int n;
      base = pushes;
      stall <= 1'b1;
      fork
         begin
            repeat (1500) @(posedge sys_clk);
            stall <= 1'b0;
         end
      join_none
      dev(8'ha0);
      wr(8'h80);
      wr(8'h45);
      check(ack, 1'b1);
      for (int k = 0; k < 66; k++) begin
         wr(8'h80 + 8'(k));
         check(ack, 1'b1);
      end
      i_host.stop();
      repeat (8) @(posedge sys_clk);
      check(busy, 1'b1);
      n = 0;
      do begin
         dev(8'ha0);
         i_host.stop();
         n++;
      end while (ack !== 1'b1 && n < 30);
      check(n > 1, 1'b1);
      check(ack, 1'b1);
      check(16'(pushes - base), 16'h42);
      for (int j = 0; j < 64; j++) begin
         check(mem[15'(64 + ((5 + j) & 63))], 16'(j < 2 ? j + 192 : j + 128));
      end
   endtask : t_page

   task automatic t_read();
      dev(8'ha0);
      wr(8'h7f);
      wr(8'hfe);
      dev(8'ha1);
      check(ack, 1'b1);
      for (int k = 0; k < 3; k++) begin
         i_host.rbyte(k < 2, rd);
         check(rd, mem[15'(32766 + k)]);
      end
      i_host.stop();
      dev(8'ha1);
      i_host.rbyte(1'b0, rd);
      check(rd, mem[15'h0001]);
      i_host.stop();
   endtask : t_read

   task automatic t_protect();
      int base;
      base = pushes;
      wp <= 1'b1;
      dev(8'ha0);
      wr(8'h00);
      wr(8'h10);
      wr(8'hee);
      check(ack, 1'b1);
      i_host.stop();
      repeat (8) @(posedge sys_clk);
      check(busy, 1'b0);
      check(16'(pushes - base), 16'h0);
      wp <= 1'b0;
   endtask : t_protect

   initial begin
      for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'h3c;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (4) @(posedge sys_clk);
      t_select();
      t_page();
      t_read();
      t_protect();
      summarize();
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      summarize();
   end
endmodule : serial_eeprom_bus_slave_bench

`default_nettype wire
